// file: src/wdt_ctrl_bits.sv
// Watchdog control register upper bits: reset flags, window enable, clock ready and interrupts
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - A late reset event sets the late flag in bit 31 whatever the window or reset enables.
// - An early reset event sets the early flag in bit 30 whatever the reset enable.
// - Each flag reads 0 with no watchdog reset of its kind and 1 after one.
// - Bit 29 at 0 allows only late events; at 1 early window events are added.
// - The read-only clock-ready bit 28 clears when software changes the enable bit.
// - Clock-ready returns to 1 once the requested enable or disable has completed.
// - With bit 27 at 1 the clock-ready rise raises an interrupt, with 0 it does not.
// - A late reset event occurs when the counter equals the late reset threshold.
// - A reset event with reset_enable at 1 asks for a system reset and a counter clear; enable and flags survive it.
module wdt_ctrl_bits #(
  parameter int CNT_W = 32  // Counter width
) (
  input  wire logic             core_clk,         // Core clock, 25 MHz
  input  wire logic             rst_n,            // Power-on reset, synchronous, active low
  input  wire logic             sys_rst_n,        // System reset, synchronous, active low
  input  wire logic [7:0]       addr,             // Register byte address
  input  wire logic [31:0]      wr_data,          // Write data
  input  wire logic             wr_en,            // Write strobe
  input  wire logic             rd_en,            // Read strobe
  output logic      [31:0]      rd_data,          // Read data, cycle after strobe
  input  wire logic             reset_enable,     // Reset generation enabled
  input  wire logic             feed,             // Feed sequence done, pulse
  input  wire logic [CNT_W-1:0] count,            // Counter value
  input  wire logic [CNT_W-1:0] late_thresh,      // Late reset threshold
  input  wire logic [CNT_W-1:0] early_thresh,     // Early reset threshold
  input  wire logic             wdt_clk_running,  // Watchdog clock status, other domain
  output logic                  enable,           // Watchdog enable bit
  output logic                  sys_reset_req,    // System reset request, pulse
  output logic                  counter_clear,    // Counter clear, pulse
  output logic                  irq               // Interrupt, level
);

  // Control state
  logic        enable_reg;
  logic        enable_next;
  logic        late_flag_reg;
  logic        late_flag_next;
  logic        early_flag_reg;
  logic        early_flag_next;
  logic        win_en_reg;
  logic        win_en_next;
  logic        clk_ready_reg;
  logic        clk_ready_next;
  logic        clk_ready_ie_reg;
  logic        clk_ready_ie_next;
  logic [2:0]  irq_status_reg;
  logic [2:0]  irq_status_next;
  logic [2:0]  irq_mask_reg;
  logic [2:0]  irq_mask_next;
  logic [31:0] rd_data_reg;
  logic [31:0] rd_data_next;
  logic        irq_reg;
  logic        sys_reset_req_reg;
  logic        counter_clear_reg;

  // Event and decode wires
  wire         late_evt;
  wire         early_evt;
  wire         clk_running_sync;
  wire         ctrl_sel;
  wire         status_sel;
  wire         mask_sel;
  wire         ctrl_wr;
  wire         status_wr;
  wire         mask_wr;
  wire         enable_change;
  wire         ready_done;
  wire         ready_rise;
  wire         reset_evt;
  wire [2:0]   irq_set;
  wire [2:0]   irq_clr;
  wire [31:0]  ctrl_word;

  // Watchdog clock status arrives from another domain
  input_sync3 u_clk_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in (wdt_clk_running),
    .sync_out (clk_running_sync)
  );

  // Late and early reset event detection
  reset_event_detect #(
    .CNT_W (CNT_W)
  ) u_detect (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .enable       (enable_reg),
    .win_en       (win_en_reg),
    .feed         (feed),
    .count        (count),
    .late_thresh  (late_thresh),
    .early_thresh (early_thresh),
    .late_evt     (late_evt),
    .early_evt    (early_evt)
  );

  // Address decode; unmapped addresses read as zero and ignore writes
  assign ctrl_sel   = (addr == wdt_ctrl_pkg::CTRL_OFFSET);
  assign status_sel = (addr == wdt_ctrl_pkg::IRQ_STATUS_OFFSET);
  assign mask_sel   = (addr == wdt_ctrl_pkg::IRQ_MASK_OFFSET);
  assign ctrl_wr    = wr_en && ctrl_sel;
  assign status_wr  = wr_en && status_sel;
  assign mask_wr    = wr_en && mask_sel;

  // Enable bit and its change request
  assign enable_change = ctrl_wr && (wr_data[wdt_ctrl_pkg::ENABLE_BIT] != enable_reg);
  assign enable_next   = ctrl_wr ? wr_data[wdt_ctrl_pkg::ENABLE_BIT] : enable_reg;

  // Reset flags: hardware set beats a software clear in the same cycle
  assign late_flag_next  = late_evt ||
                           (late_flag_reg &&
                            !(ctrl_wr && !wr_data[wdt_ctrl_pkg::LATE_FLAG_BIT]));
  assign early_flag_next = early_evt ||
                           (early_flag_reg &&
                            !(ctrl_wr && !wr_data[wdt_ctrl_pkg::EARLY_FLAG_BIT]));

  // Plain read-write configuration bits
  assign win_en_next       = ctrl_wr ? wr_data[wdt_ctrl_pkg::WIN_EN_BIT] : win_en_reg;
  assign clk_ready_ie_next = ctrl_wr ? wr_data[wdt_ctrl_pkg::CLK_READY_IE_BIT]
                                     : clk_ready_ie_reg;
  assign irq_mask_next     = mask_wr ? wr_data[2:0] : irq_mask_reg;

  // Clock ready: drops on an enable change, rises once the clock status matches the request
  assign ready_done     = (clk_running_sync == enable_reg);
  assign clk_ready_next = enable_change ? 1'b0 :
                          (ready_done ? 1'b1 : clk_ready_reg);
  assign ready_rise     = clk_ready_next && !clk_ready_reg;

  // Any reset event of either kind drives the system reset path
  assign reset_evt = late_evt || early_evt;

  // Interrupt status events; clock-ready only counts while its enable is set
  assign irq_set = {ready_rise && clk_ready_ie_reg, early_evt, late_evt};
  assign irq_clr = status_wr ? wr_data[2:0] : 3'h0;
  assign irq_status_next = wdt_ctrl_pkg::w1c_update(irq_status_reg, irq_set, irq_clr);

  // Control word as software sees it; fields owned elsewhere read as zero here
  assign ctrl_word = {late_flag_reg, early_flag_reg, win_en_reg, clk_ready_reg,
                      clk_ready_ie_reg, 26'h000_0000, enable_reg};

  // Read mux, registered so data stand in the cycle after the strobe only
  assign rd_data_next = !rd_en     ? wdt_ctrl_pkg::DATA_RESET :
                        ctrl_sel   ? ctrl_word :
                        status_sel ? {29'h0000_0000, irq_status_reg} :
                        mask_sel   ? {29'h0000_0000, irq_mask_reg} :
                                     wdt_ctrl_pkg::DATA_RESET;

  // State that survives a system reset: enable, both reset flags and clock ready
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      enable_reg     <= 1'b0;
      late_flag_reg  <= 1'b0;
      early_flag_reg <= 1'b0;
      clk_ready_reg  <= 1'b0;
    end else begin
      enable_reg     <= enable_next;
      late_flag_reg  <= late_flag_next;
      early_flag_reg <= early_flag_next;
      clk_ready_reg  <= clk_ready_next;
    end
  end

  // Configuration cleared by either reset
  always_ff @(posedge core_clk) begin
    if (!rst_n || !sys_rst_n) begin
      win_en_reg       <= 1'b0;
      clk_ready_ie_reg <= 1'b0;
      irq_status_reg   <= wdt_ctrl_pkg::IRQ_RESET;
      irq_mask_reg     <= wdt_ctrl_pkg::IRQ_RESET;
    end else begin
      win_en_reg       <= win_en_next;
      clk_ready_ie_reg <= clk_ready_ie_next;
      irq_status_reg   <= irq_status_next;
      irq_mask_reg     <= irq_mask_next;
    end
  end

  // Registered outputs; the reset request is gated by the reset enable, the flags are not
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_data_reg       <= wdt_ctrl_pkg::DATA_RESET;
      irq_reg           <= 1'b0;
      sys_reset_req_reg <= 1'b0;
      counter_clear_reg <= 1'b0;
    end else begin
      rd_data_reg       <= rd_data_next;
      irq_reg           <= |(irq_status_next & irq_mask_next);
      sys_reset_req_reg <= reset_evt && reset_enable;
      counter_clear_reg <= reset_evt && reset_enable;
    end
  end

  assign rd_data       = rd_data_reg;
  assign enable        = enable_reg;
  assign irq           = irq_reg;
  assign sys_reset_req = sys_reset_req_reg;
  assign counter_clear = counter_clear_reg;

endmodule

// file: src/wdt_ctrl_pkg.sv
// Package with register map, field positions and reset values of the watchdog control bits
package wdt_ctrl_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET       = 8'h00;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFFSET   = 8'h14;

  // Field positions in the watchdog control register
  localparam int LATE_FLAG_BIT   = 31;
  localparam int EARLY_FLAG_BIT  = 30;
  localparam int WIN_EN_BIT      = 29;
  localparam int CLK_READY_BIT   = 28;
  localparam int CLK_READY_IE_BIT = 27;
  localparam int ENABLE_BIT      = 0;

  // Field positions in the interrupt status and mask registers
  localparam int IRQ_WIDTH       = 3;
  localparam int IRQ_LATE_BIT    = 0;
  localparam int IRQ_EARLY_BIT   = 1;
  localparam int IRQ_CLKRDY_BIT  = 2;

  // Reset values
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [2:0]  IRQ_RESET  = 3'h0;

  // Write-one-to-clear update where a new event beats the clear
  function automatic logic [IRQ_WIDTH-1:0] w1c_update(
    input logic [IRQ_WIDTH-1:0] cur,
    input logic [IRQ_WIDTH-1:0] set,
    input logic [IRQ_WIDTH-1:0] clr
  );
    w1c_update = set | (cur & ~clr);
  endfunction

endpackage

// file: src/input_sync3.sv
// Three-stage synchroniser for a level from outside the core clock domain
`timescale 1ns/1ps
module input_sync3 (
  input  wire logic core_clk,  // Core clock
  input  wire logic rst_n,     // Synchronous reset, active low
  input  wire logic async_in,  // Level from another domain
  output logic      sync_out   // Filtered level
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic out_reg;

  // First stage feeds only the second; output moves once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_reg  <= 1'b0;
      s2_reg  <= 1'b0;
      s3_reg  <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        out_reg <= s3_reg;
      end
    end
  end

  assign sync_out = out_reg;

endmodule

// file: src/reset_event_detect.sv
// Detector of late and early watchdog reset events from counter and thresholds
`timescale 1ns/1ps
module reset_event_detect #(
  parameter int CNT_W = 32  // Counter width
) (
  input  wire logic             core_clk,     // Core clock
  input  wire logic             rst_n,        // Synchronous reset, active low
  input  wire logic             enable,       // Watchdog running
  input  wire logic             win_en,       // Window function enabled
  input  wire logic             feed,         // Feed sequence completed, pulse
  input  wire logic [CNT_W-1:0] count,        // Counter value
  input  wire logic [CNT_W-1:0] late_thresh,  // Late reset threshold
  input  wire logic [CNT_W-1:0] early_thresh, // Early reset threshold
  output logic                  late_evt,     // Late reset event, pulse
  output logic                  early_evt     // Early reset event, pulse
);

  logic hit_reg;
  logic late_reg;
  logic early_reg;
  wire  late_hit;
  wire  early_hit;

  // Counter may sit on the threshold for many core cycles, so only the first counts
  assign late_hit  = enable && (count == late_thresh);
  // Early events exist only with the window function on
  assign early_hit = enable && win_en && feed && (count < early_thresh);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hit_reg   <= 1'b0;
      late_reg  <= 1'b0;
      early_reg <= 1'b0;
    end else begin
      hit_reg   <= late_hit;
      late_reg  <= late_hit && !hit_reg;
      early_reg <= early_hit;
    end
  end

  assign late_evt  = late_reg;
  assign early_evt = early_reg;

endmodule

// file: dv/wdt_ctrl_bits_sva.sv
// Port checker for the watchdog control bits
`timescale 1ns/1ps
module wdt_ctrl_bits_sva #(
  parameter int CNT_W = 32  // Counter width
) (
  input wire logic             core_clk,      // Clock
  input wire logic             rst_n,         // Reset
  input wire logic [7:0]       addr,          // Address
  input wire logic [31:0]      wr_data,       // Write data
  input wire logic             wr_en,         // Write strobe
  input wire logic             rd_en,         // Read strobe
  input wire logic [31:0]      rd_data,       // Read data
  input wire logic             reset_enable,  // Reset allowed
  input wire logic [CNT_W-1:0] count,         // Counter
  input wire logic [CNT_W-1:0] late_thresh,   // Late threshold
  input wire logic             enable,        // Enable bit
  input wire logic             sys_reset_req, // Reset request
  input wire logic             counter_clear, // Counter clear
  input wire logic             irq            // Interrupt
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Decodes shared by the properties
  wire late_hit = enable && count == late_thresh;
  wire ctrl_wr  = wr_en && addr == wdt_ctrl_pkg::CTRL_OFFSET;
  wire mask_off = wr_en && addr == wdt_ctrl_pkg::IRQ_MASK_OFFSET && wr_data[2:0] == 3'h0;
  a_read_idle_zero: assert property (!$past(rd_en) |-> rd_data == 32'h0000_0000)
    else $error("read data not zero outside read");
  a_unmapped_read: assert property ($past(rd_en) && $past(addr) == 8'h04 |-> rd_data == 0)
    else $error("unmapped read not zero");
  a_enable_write: assert property (ctrl_wr |=> enable == $past(wr_data[0]))
    else $error("enable not written");
  a_enable_hold: assert property (!ctrl_wr |=> $stable(enable))
    else $error("enable moved without write");
  a_ready_clear: assert property (ctrl_wr && wr_data[0] != enable ##2
    rd_en && addr == wdt_ctrl_pkg::CTRL_OFFSET |=> !rd_data[28])
    else $error("clock ready not cleared");
  a_late_req: assert property ($rose(late_hit) ##1 reset_enable |=> sys_reset_req)
    else $error("late event gave no reset request");
  a_req_cause: assert property (sys_reset_req |-> $past(reset_enable))
    else $error("reset request while reset disabled");
  a_clear_pair: assert property (counter_clear == sys_reset_req)
    else $error("counter clear apart from reset request");
  a_mask_irq_off: assert property (mask_off |=> !irq)
    else $error("irq high with all masked");
  // Main scenarios reached
  c_req: cover property (sys_reset_req);
  c_irq: cover property ($rose(irq));
  c_enable: cover property (ctrl_wr && wr_data[0]);
endmodule
bind wdt_ctrl_bits wdt_ctrl_bits_sva #(.CNT_W(CNT_W)) u_sva (.core_clk(core_clk),
  .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data(rd_data), .reset_enable(reset_enable), .count(count),
  .late_thresh(late_thresh), .enable(enable), .sys_reset_req(sys_reset_req),
  .counter_clear(counter_clear), .irq(irq));

// file: dv/wdt_ctrl_bits_tb_top.sv
// Bench for the watchdog control bits
`timescale 1ns/1ps
module wdt_ctrl_bits_tb_top;
  localparam logic [7:0] CT = wdt_ctrl_pkg::CTRL_OFFSET;
  localparam logic [7:0] ST = wdt_ctrl_pkg::IRQ_STATUS_OFFSET;
  localparam logic [7:0] MK = wdt_ctrl_pkg::IRQ_MASK_OFFSET;
  logic        core_clk = 0, rst_n = 0, sys_rst_n = 0, wr_en = 0, rd_en = 0;
  logic        reset_enable = 0, feed = 0, wdt_clk_running = 0;
  logic [7:0]  addr = 8'h00, count = 8'h00, late_thresh = 8'hf0, early_thresh = 8'h40;
  logic [31:0] wr_data = 32'h0000_0000, d, rd_data;
  logic        enable, sys_reset_req, counter_clear, irq, seen, seen_clr;
  int          n_errors = 0, n_compared = 0, cyc = 0;
  wdt_ctrl_bits #(.CNT_W(8)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .sys_rst_n(sys_rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .reset_enable(reset_enable), .feed(feed), .count(count),
    .late_thresh(late_thresh), .early_thresh(early_thresh),
    .wdt_clk_running(wdt_clk_running), .enable(enable), .sys_reset_req(sys_reset_req),
    .counter_clear(counter_clear), .irq(irq));
  always #20 core_clk = ~core_clk;
  // Hang guard, far above the roughly 130 cycles the run needs
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors = n_errors + 1;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(negedge core_clk);
    d = rd_data;
  endtask
  task automatic watch(input int n);
    seen = 1'b0;
    seen_clr = 1'b0;
    repeat (n) begin
      @(negedge core_clk);
      seen = seen | (sys_reset_req === 1'b1);
      seen_clr = seen_clr | (counter_clear === 1'b1);
    end
  endtask
  task automatic clk_run(input logic v);
    @(posedge core_clk);
    wdt_clk_running <= v;
    repeat (10) @(negedge core_clk);
  endtask
  task automatic t_reset;
    rd(CT);
    chk(d & 32'hefff_ffff, 32'h0000_0000);
    rd(8'h04);
    chk(d, 32'h0000_0000);
  endtask
  // Enable and disable, each followed by the clock-ready handshake
  task automatic t_ready;
    wr(MK, 32'h0000_0007);
    wr(CT, 32'h0800_0001);
    rd(CT);
    chk(d & 32'h1000_0000, 32'h0000_0000);
    clk_run(1'b1);
    rd(CT);
    chk(d & 32'h1800_0001, 32'h1800_0001);
    rd(ST);
    chk(d, 32'h0000_0004);
    chk({31'h0, irq}, 32'h1);
    wr(ST, 32'h0000_0004);
    @(negedge core_clk);
    chk({31'h0, irq}, 32'h0);
    wr(CT, 32'h0000_0000);
    rd(CT);
    chk(d & 32'h1000_0000, 32'h0000_0000);
    clk_run(1'b0);
    rd(CT);
    chk(d & 32'h1000_0001, 32'h1000_0000);
    rd(ST);
    chk(d, 32'h0000_0000);
    wr(CT, 32'h0000_0001);
    clk_run(1'b1);
  endtask
  // Late event with and without reset generation, then flag write rules
  task automatic t_late(input logic re);
    @(posedge core_clk);
    reset_enable <= re;
    count <= late_thresh;
    watch(6);
    chk({31'h0, seen}, {31'h0, re});
    chk({31'h0, seen_clr}, {31'h0, re});
    @(posedge core_clk);
    count <= 8'h00;
    sys_rst_n <= ~re;
    repeat (2) @(posedge core_clk);
    sys_rst_n <= 1'b1;
    rd(CT);
    chk(d & 32'he000_0001, 32'h8000_0001);
    chk({31'h0, enable}, 32'h1);
    wr(CT, 32'h8000_0001);
    rd(CT);
    chk(d & 32'h8000_0000, 32'h8000_0000);
    wr(CT, 32'h0000_0001);
    rd(CT);
    chk(d & 32'hc000_0000, 32'h0000_0000);
    wr(ST, 32'h0000_0007);
  endtask
  task automatic t_early(input logic [31:0] v, input logic ex);
    wr(CT, v);
    @(posedge core_clk);
    feed <= 1'b1;
    @(posedge core_clk);
    feed <= 1'b0;
    watch(4);
    chk({31'h0, seen}, {31'h0, ex});
    rd(CT);
    chk(d & 32'h4000_0001, {1'b0, ex, 29'h0, 1'b1});
  endtask
  task automatic report_and_stop;
    if (n_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    sys_rst_n <= 1'b1;
    t_reset();
    t_ready();
    t_late(1'b0);
    t_late(1'b1);
    t_early(32'h0000_0001, 1'b0);
    t_early(32'h2000_0001, 1'b1);
    wr(MK, 32'h0000_0007);
    wr(MK, 32'h0000_0000);
    @(negedge core_clk);
    chk({31'h0, irq}, 32'h0);
    report_and_stop();
  end
endmodule
